//--- shared/bcdrtc_pkg.sv
package bcdrtc_pkg;
  localparam int          ADDR_W       = 4;
  localparam logic [3:0]  OFS_SEC      = 4'h0;
  localparam logic [3:0]  OFS_MIN      = 4'h1;
  localparam logic [3:0]  OFS_HOUR     = 4'h2;
  localparam logic [3:0]  OFS_WDAY     = 4'h3;
  localparam logic [3:0]  OFS_DAY      = 4'h4;
  localparam logic [3:0]  OFS_MON      = 4'h5;
  localparam logic [3:0]  OFS_YEAR     = 4'h6;
  localparam logic [7:0]  MASK_SEC     = 8'h7F;
  localparam logic [7:0]  MASK_MIN     = 8'h7F;
  localparam logic [7:0]  MASK_HOUR    = 8'h3F;
  localparam logic [7:0]  MASK_WDAY    = 8'h07;
  localparam logic [7:0]  MASK_DAY     = 8'h3F;
  localparam logic [7:0]  MASK_MON     = 8'h1F;
  localparam logic [7:0]  MASK_YEAR    = 8'hFF;
  localparam logic [7:0]  RST_SEC      = 8'h00;
  localparam logic [7:0]  RST_MIN      = 8'h00;
  localparam logic [7:0]  RST_HOUR     = 8'h12;
  localparam logic [7:0]  RST_WDAY     = 8'h00;
  localparam logic [7:0]  RST_DAY      = 8'h01;
  localparam logic [7:0]  RST_MON      = 8'h01;
  localparam logic [7:0]  RST_YEAR     = 8'h00;
  localparam logic [7:0]  BCD_59       = 8'h59;
  localparam logic [7:0]  BCD_23       = 8'h23;
  localparam logic [7:0]  BCD_11       = 8'h11;
  localparam logic [7:0]  BCD_12       = 8'h12;
  localparam logic [7:0]  BCD_99       = 8'h99;
  localparam logic [7:0]  BCD_01       = 8'h01;
  localparam logic [7:0]  BCD_00       = 8'h00;
  localparam logic [7:0]  BCD_31       = 8'h31;
  localparam logic [7:0]  BCD_30       = 8'h30;
  localparam logic [7:0]  BCD_29       = 8'h29;
  localparam logic [7:0]  BCD_28       = 8'h28;
  localparam logic [7:0]  BCD_FEB      = 8'h02;
  localparam logic [2:0]  WDAY_LAST    = 3'h6;
  localparam int          PM_BIT       = 5;
  localparam logic [7:0]  UNDEF_DIGITS = 8'h00;
endpackage : bcdrtc_pkg

//--- verification/bcdrtc_core_tb.sv
`timescale 1ns/1ps
module bcdrtc_core_tb
  import bcdrtc_pkg::*;
;
  logic              clk, rst, sec_tick, hour_24, osc_halt_detected, rd_q;
  logic              first_alarm_enable, second_alarm_enable;
  logic              first_alarm_clear, second_alarm_clear;
  logic              first_alarm_match_flag, second_alarm_match_flag;
  logic              irq_out_first_n, irq_out_second_n, reg_wr, reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0]        reg_wdata, reg_rdata, exp_v;
  logic [6:0]        first_alarm_minute, first_alarm_weekdays;
  logic [6:0]        second_alarm_minute, second_alarm_weekdays;
  logic [5:0]        first_alarm_hour, second_alarm_hour;
  logic [7:0]        exp_q[$];
  logic [7:0]        last_day[12];
  logic [7:0]        rv[7];
  logic [7:0]        wv[7];
  logic [7:0]        ev[7];
  int                err_total, checks, cyc, seed, y;

  bcdrtc_host i_bcdrtc_host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  bcdrtc_core i_bcdrtc_core (.clk, .rst, .sec_tick, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .hour_24, .osc_halt_detected, .first_alarm_enable, .second_alarm_enable,
    .first_alarm_minute, .first_alarm_hour, .first_alarm_weekdays, .second_alarm_minute,
    .second_alarm_hour, .second_alarm_weekdays, .first_alarm_clear, .second_alarm_clear,
    .first_alarm_match_flag, .second_alarm_match_flag, .irq_out_first_n, .irq_out_second_n);

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic end_sim;
    if (err_total == 0 && checks > 0 && exp_q.size() == 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t alarm output %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // read results appear one cycle after the strobe
  always @(posedge clk) rd_q <= reg_rd;
  always @(negedge clk)
    if (rd_q === 1'b1)
    begin
      exp_v = exp_q.pop_front();
      chk_byte(reg_rdata, exp_v);
    end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      end_sim;
    end
  end

  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction : bcd

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    i_bcdrtc_host.wr(a, d);
  endtask : wr

  task automatic rd_exp(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_bcdrtc_host.rd(a);
  endtask : rd_exp

  task automatic tick;
    @(negedge clk);
    sec_tick = 1'b1;
    @(negedge clk);
    sec_tick = 1'b0;
  endtask : tick

  task automatic set_time(input logic [7:0] h, input logic [7:0] m, input logic [7:0] s);
    wr(OFS_HOUR, h);
    wr(OFS_MIN, m);
    wr(OFS_SEC, s);
  endtask : set_time

  task automatic roll(input logic [7:0] mo, dd, yr, ed, em, ey);
    wr(OFS_YEAR, yr);
    wr(OFS_MON, mo);
    wr(OFS_DAY, dd);
    wr(OFS_WDAY, 8'h06);
    set_time(8'h23, 8'h59, 8'h59);
    tick;
    rd_exp(OFS_SEC, 8'h00);
    rd_exp(OFS_MIN, 8'h00);
    rd_exp(OFS_HOUR, 8'h00);
    rd_exp(OFS_WDAY, 8'h00);
    rd_exp(OFS_DAY, ed);
    rd_exp(OFS_MON, em);
    rd_exp(OFS_YEAR, ey);
  endtask : roll

  task automatic hr12(input logic [7:0] h, input logic [7:0] eh, input logic [7:0] ed);
    wr(OFS_DAY, 8'h10);
    wr(OFS_WDAY, 8'h03);
    set_time(h, 8'h59, 8'h59);
    tick;
    rd_exp(OFS_HOUR, eh);
    rd_exp(OFS_DAY, ed);
    rd_exp(OFS_WDAY, (ed == 8'h11) ? 8'h04 : 8'h03);
  endtask : hr12

  task automatic alarm_hit(input logic [7:0] wd);
    wr(OFS_WDAY, wd);
    set_time(8'h10, 8'h29, 8'h59);
    tick;
    repeat (4) @(negedge clk);
  endtask : alarm_hit

  initial
  begin
    seed = 32'haeea2247;
    rst = 1'b1;
    sec_tick = 1'b0;
    hour_24 = 1'b1;  // format chosen before any time write
    osc_halt_detected = 1'b0;
    first_alarm_enable = 1'b0;
    second_alarm_enable = 1'b0;
    first_alarm_clear = 1'b0;
    second_alarm_clear = 1'b0;
    first_alarm_minute = 7'h30;
    first_alarm_hour = 6'h10;
    first_alarm_weekdays = 7'h04;
    second_alarm_minute = 7'h30;
    second_alarm_hour = 6'h10;
    second_alarm_weekdays = 7'h04;
    last_day = '{8'h31, 8'h28, 8'h31, 8'h30, 8'h31, 8'h30, 8'h31, 8'h31, 8'h30, 8'h31, 8'h30, 8'h31};
    rv = '{8'h00, 8'h00, 8'h12, 8'h00, 8'h01, 8'h01, 8'h00};
    wv = '{8'hC5, 8'hB7, 8'hD9, 8'hFD, 8'hE8, 8'hE9, 8'h73};
    ev = '{8'h45, 8'h37, 8'h19, 8'h05, 8'h28, 8'h09, 8'h73};
    repeat (10) @(negedge clk);
    rst = 1'b0;
    for (int a = 0; a < 7; a++)
      rd_exp(4'(a), rv[a]);
    for (int a = 0; a < 7; a++)
      wr(4'(a), wv[a]);
    for (int a = 0; a < 7; a++)
      rd_exp(4'(a), ev[a]);
    wr(4'h7, 8'h55);
    rd_exp(4'h7, 8'h00);
    rd_exp(4'hF, 8'h00);
    wr(OFS_SEC, 8'h08);
    tick;
    tick;
    rd_exp(OFS_SEC, 8'h10);
    rd_exp(OFS_MIN, 8'h37);
    for (int m = 1; m <= 12; m++)
      roll(bcd(m), last_day[m-1], 8'h01, 8'h01, bcd(m % 12 + 1), (m == 12) ? 8'h02 : 8'h01);
    roll(8'h02, 8'h28, 8'h04, 8'h29, 8'h02, 8'h04);
    roll(8'h02, 8'h29, 8'h00, 8'h01, 8'h03, 8'h00);
    roll(8'h12, 8'h31, 8'h99, 8'h01, 8'h01, 8'h00);
    repeat (4)
    begin
      y = ($random(seed) & 32'h7FFFFFFF) % 100;
      roll(8'h02, 8'h28, bcd(y), (y % 4 == 0) ? 8'h29 : 8'h01, (y % 4 == 0) ? 8'h02 : 8'h03,
        bcd(y));
    end
    hour_24 = 1'b0;
    hr12(8'h31, 8'h12, 8'h11);
    hr12(8'h11, 8'h32, 8'h10);
    hr12(8'h12, 8'h01, 8'h10);
    hr12(8'h32, 8'h21, 8'h10);
    hour_24 = 1'b1;
    first_alarm_enable = 1'b1;
    alarm_hit(8'h02);
    chk_bit(first_alarm_match_flag, 1'b1);
    chk_bit(irq_out_first_n, 1'b0);
    chk_bit(second_alarm_match_flag, 1'b0);
    chk_bit(irq_out_second_n, 1'b1);
    second_alarm_enable = 1'b1;
    repeat (2) @(negedge clk);
    chk_bit(second_alarm_match_flag, 1'b0);
    first_alarm_clear = 1'b1;
    @(negedge clk);
    first_alarm_clear = 1'b0;
    repeat (3) @(negedge clk);
    chk_bit(first_alarm_match_flag, 1'b0);
    chk_bit(irq_out_first_n, 1'b1);
    alarm_hit(8'h02);
    chk_bit(second_alarm_match_flag, 1'b1);
    chk_bit(irq_out_second_n, 1'b0);
    first_alarm_enable = 1'b0;
    repeat (2) @(negedge clk);
    chk_bit(first_alarm_match_flag, 1'b0);
    chk_bit(irq_out_first_n, 1'b1);
    second_alarm_clear = 1'b1;
    @(negedge clk);
    second_alarm_clear = 1'b0;
    alarm_hit(8'h03);
    chk_bit(second_alarm_match_flag, 1'b0);
    chk_bit(irq_out_second_n, 1'b1);
    osc_halt_detected = 1'b1;
    for (int a = 0; a < 7; a++)
      rd_exp(4'(a), 8'h00);
    repeat (4) @(negedge clk);
    end_sim;
  end
endmodule : bcdrtc_core_tb

//--- verification/bcdrtc_host.sv
`timescale 1ns/1ps
module bcdrtc_host
  import bcdrtc_pkg::*;
(
  input  wire logic              clk,
  output logic                   reg_wr,
  output logic                   reg_rd,
  output logic      [ADDR_W-1:0] reg_addr,
  output logic      [7:0]        reg_wdata
);
  initial
  begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 8'hA5;
  end
  // one write beat; callers also pass bits outside the field masks, weekday code FD and the unused offset 7
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask : wr
  // one read strobe, data taken by the bench a cycle later
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
  endtask : rd
endmodule : bcdrtc_host

//--- verilog/bcdrtc_alarm.sv
`timescale 1ns/1ps
module bcdrtc_alarm
  import bcdrtc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       enable,
  input  wire logic       match_hit,
  input  wire logic       clear_req,
  output logic            flag,
  output logic            irq_n
);
  logic flag_raw;

  // sticky match flag; set beats clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flag_raw <= 1'b0;
    else if (!enable)
      flag_raw <= 1'b0;
    else if (match_hit)
      flag_raw <= 1'b1;
    else if (clear_req)
      flag_raw <= 1'b0;
  end

  assign flag = flag_raw & enable;

  // interrupt goes low the cycle after flagged and enabled
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_n <= 1'b1;
    else
      irq_n <= !(flag_raw && enable);
  end

  sequence hit_s;
    enable && match_hit;
  endsequence

  property irq_follows_p;
    @(posedge clk) disable iff (rst) ##1 1 |-> irq_n == !$past(flag_raw && enable);
  endproperty
  irq_follow_a: assert property (irq_follows_p)
    else $error("irq output does not follow flag and enable");
  hit_sets_a: assert property (@(posedge clk) disable iff (rst)
      hit_s ##1 enable |-> flag)
    else $error("match did not set flag");
  off_reads_zero_a: assert property (@(posedge clk) disable iff (rst)
      !enable |=> !flag_raw)
    else $error("flag kept while disabled");
  clear_works_a: assert property (@(posedge clk) disable iff (rst)
      clear_req && !match_hit |=> !flag_raw)
    else $error("clear did not drop flag");
  clear_irq_a: assert property (@(posedge clk) disable iff (rst)
      clear_req && !match_hit |=> ##1 irq_n)
    else $error("clear did not release irq");
  disabled_quiet_a: assert property (@(posedge clk) disable iff (rst)
      !enable ##1 1 |-> irq_n)
    else $error("irq asserted while disabled");
endmodule : bcdrtc_alarm

//--- verilog/bcdrtc_core.sv
`timescale 1ns/1ps
module bcdrtc_core
  import bcdrtc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              sec_tick,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  input  wire logic              hour_24,
  input  wire logic              osc_halt_detected,
  input  wire logic              first_alarm_enable,
  input  wire logic              second_alarm_enable,
  input  wire logic [6:0]        first_alarm_minute,
  input  wire logic [5:0]        first_alarm_hour,
  input  wire logic [6:0]        first_alarm_weekdays,
  input  wire logic [6:0]        second_alarm_minute,
  input  wire logic [5:0]        second_alarm_hour,
  input  wire logic [6:0]        second_alarm_weekdays,
  input  wire logic              first_alarm_clear,
  input  wire logic              second_alarm_clear,
  output logic                   first_alarm_match_flag,
  output logic                   second_alarm_match_flag,
  output logic                   irq_out_first_n,
  output logic                   irq_out_second_n
);
  logic [7:0] seconds_count;
  logic [7:0] minutes_count;
  logic [7:0] hours_count;
  logic [2:0] weekday_count;
  logic [7:0] day_of_month_count;
  logic [7:0] month_count;
  logic [7:0] year_count;
  logic       sec_wrap;
  logic       min_wrap;
  logic       hour_wrap;
  logic       day_wrap;
  logic       mon_wrap;
  logic [7:0] next_hour;
  logic [7:0] day_max;
  logic       leap;
  logic       min_edge;
  logic       hit_first;
  logic       hit_second;
  logic       flag_first;
  logic       flag_second;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] ofs);
    wr_hit = reg_wr && (a == ofs);
  endfunction : wr_hit

  assign sec_wrap  = sec_tick && (seconds_count == BCD_59);
  assign min_wrap  = sec_wrap && (minutes_count == BCD_59);
  assign hour_wrap = min_wrap && (hour_24 ? (hours_count == BCD_23)
                     : (hours_count == {2'b00, 1'b1, BCD_11[4:0]}));
  // leap when year mod 4 is zero, tens parity folds in
  assign leap = (year_count[4] == 1'b0) ? (year_count[1:0] == 2'b00)
                : (year_count[1:0] == 2'b10);

  always_comb
  begin
    unique case (month_count)
      8'h04, 8'h06, 8'h09, 8'h11: day_max = BCD_30;
      BCD_FEB:                    day_max = leap ? BCD_29 : BCD_28;
      default:                    day_max = BCD_31;
    endcase
  end

  assign day_wrap = hour_wrap && (day_of_month_count == day_max);
  assign mon_wrap = day_wrap && (month_count == BCD_12);

  // hour step for both formats
  always_comb
  begin
    next_hour = bcd_inc(hours_count);
    if (hour_24)
    begin
      if (hours_count == BCD_23)
        next_hour = BCD_00;
    end
    else
    begin
      if (hours_count[4:0] == BCD_12[4:0])
        next_hour = {hours_count[7:5], 5'h01};
      else if (hours_count[4:0] == BCD_11[4:0])
        next_hour = {hours_count[7:6], ~hours_count[PM_BIT], 5'h12};
      else
        next_hour = {hours_count[7:5], next_hour[4:0]};
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      seconds_count <= RST_SEC;
    else if (wr_hit(reg_addr, OFS_SEC))
      seconds_count <= reg_wdata & MASK_SEC;
    else if (sec_tick)
      seconds_count <= sec_wrap ? BCD_00 : bcd_inc(seconds_count);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      minutes_count <= RST_MIN;
    else if (wr_hit(reg_addr, OFS_MIN))
      minutes_count <= reg_wdata & MASK_MIN;
    else if (sec_wrap)
      minutes_count <= min_wrap ? BCD_00 : bcd_inc(minutes_count);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hours_count <= RST_HOUR;
    else if (wr_hit(reg_addr, OFS_HOUR))
      hours_count <= reg_wdata & MASK_HOUR;
    else if (min_wrap)
      hours_count <= next_hour;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      weekday_count <= RST_WDAY[2:0];
    else if (wr_hit(reg_addr, OFS_WDAY))
      weekday_count <= reg_wdata[2:0];
    else if (hour_wrap)
      weekday_count <= (weekday_count == WDAY_LAST) ? 3'h0 : weekday_count + 3'h1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      day_of_month_count <= RST_DAY;
    else if (wr_hit(reg_addr, OFS_DAY))
      day_of_month_count <= reg_wdata & MASK_DAY;
    else if (hour_wrap)
      day_of_month_count <= day_wrap ? BCD_01 : bcd_inc(day_of_month_count);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      month_count <= RST_MON;
    else if (wr_hit(reg_addr, OFS_MON))
      month_count <= reg_wdata & MASK_MON;
    else if (day_wrap)
      month_count <= mon_wrap ? BCD_01 : bcd_inc(month_count);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      year_count <= RST_YEAR;
    else if (wr_hit(reg_addr, OFS_YEAR))
      year_count <= reg_wdata & MASK_YEAR;
    else if (mon_wrap)
      year_count <= (year_count == BCD_99) ? BCD_00 : bcd_inc(year_count);
  end

  // read mux; digits forced to a fixed value after halt, upper bits zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      if (osc_halt_detected)
        reg_rdata <= UNDEF_DIGITS;
      else
      begin
        unique case (reg_addr)
          OFS_SEC:  reg_rdata <= seconds_count & MASK_SEC;
          OFS_MIN:  reg_rdata <= minutes_count & MASK_MIN;
          OFS_HOUR: reg_rdata <= hours_count & MASK_HOUR;
          OFS_WDAY: reg_rdata <= {5'h00, weekday_count};
          OFS_DAY:  reg_rdata <= day_of_month_count & MASK_DAY;
          OFS_MON:  reg_rdata <= month_count & MASK_MON;
          OFS_YEAR: reg_rdata <= year_count;
          default:  reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // compare once per new minute
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      min_edge <= 1'b0;
    else
      min_edge <= sec_wrap;
  end

  assign hit_first  = min_edge && first_alarm_enable
                      && (minutes_count[6:0] == first_alarm_minute)
                      && (hours_count[5:0] == first_alarm_hour)
                      && first_alarm_weekdays[weekday_count];
  assign hit_second = min_edge && second_alarm_enable
                      && (minutes_count[6:0] == second_alarm_minute)
                      && (hours_count[5:0] == second_alarm_hour)
                      && second_alarm_weekdays[weekday_count];

  bcdrtc_alarm u_alarm_first (
    .clk       (clk),
    .rst       (rst),
    .enable    (first_alarm_enable),
    .match_hit (hit_first),
    .clear_req (first_alarm_clear),
    .flag      (flag_first),
    .irq_n     (irq_out_first_n)
  );

  bcdrtc_alarm u_alarm_second (
    .clk       (clk),
    .rst       (rst),
    .enable    (second_alarm_enable),
    .match_hit (hit_second),
    .clear_req (second_alarm_clear),
    .flag      (flag_second),
    .irq_n     (irq_out_second_n)
  );

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      first_alarm_match_flag  <= 1'b0;
      second_alarm_match_flag <= 1'b0;
    end
    else
    begin
      first_alarm_match_flag  <= flag_first && first_alarm_enable;
      second_alarm_match_flag <= flag_second && second_alarm_enable;
    end
  end

  // carry steps and alarm pipeline
  sequence day_carry_s;
    hour_wrap && !reg_wr;
  endsequence

  sequence month_end_s;
    day_wrap && !reg_wr;
  endsequence

  sequence year_end_s;
    mon_wrap && !reg_wr;
  endsequence

  sequence first_hit_s;
    hit_first ##1 first_alarm_enable;
  endsequence

  sequence second_hit_s;
    hit_second ##1 second_alarm_enable;
  endsequence

  sec_wrap_a: assert property (@(posedge clk) disable iff (rst)
      sec_tick && seconds_count == BCD_59 && !reg_wr |=> seconds_count == BCD_00)
    else $error("seconds did not wrap to 00");
  min_carry_a: assert property (@(posedge clk) disable iff (rst)
      sec_wrap && !reg_wr |=> minutes_count != $past(minutes_count))
    else $error("minutes missed carry");
  no_tick_hold_a: assert property (@(posedge clk) disable iff (rst)
      !sec_tick && !reg_wr |=> $stable(seconds_count))
    else $error("seconds moved without tick");
  hour_wrap24_a: assert property (@(posedge clk) disable iff (rst)
      day_carry_s ##0 (hour_24 && hours_count == BCD_23)
      |=> hours_count == BCD_00 && day_of_month_count != $past(day_of_month_count))
    else $error("hour wrap or day carry wrong");
  hour_wrap12_a: assert property (@(posedge clk) disable iff (rst)
      day_carry_s ##0 !hour_24 |=> hours_count == BCD_12)
    else $error("12-hour wrap did not reach 12 am");
  wday_wrap_a: assert property (@(posedge clk) disable iff (rst)
      day_carry_s ##0 (weekday_count == WDAY_LAST) |=> weekday_count == 3'h0)
    else $error("weekday did not wrap after six");
  wday_step_a: assert property (@(posedge clk) disable iff (rst)
      day_carry_s ##0 (weekday_count != WDAY_LAST)
      |=> weekday_count == $past(weekday_count) + 3'h1)
    else $error("weekday did not step on day carry");
  feb_leap_a: assert property (@(posedge clk) disable iff (rst)
      month_count == BCD_FEB && year_count == BCD_00 |-> day_max == BCD_29)
    else $error("year 00 not leap");
  day_roll_a: assert property (@(posedge clk) disable iff (rst)
      month_end_s |=> day_of_month_count == BCD_01)
    else $error("day did not roll to 1");
  month_step_a: assert property (@(posedge clk) disable iff (rst)
      month_end_s ##0 (month_count != BCD_12) |=> month_count != $past(month_count))
    else $error("month missed day carry");
  mon_wrap_a: assert property (@(posedge clk) disable iff (rst)
      year_end_s |=> month_count == BCD_01)
    else $error("month did not wrap to 1");
  year_step_a: assert property (@(posedge clk) disable iff (rst)
      year_end_s |=> year_count != $past(year_count))
    else $error("year missed month carry");
  year_roll_a: assert property (@(posedge clk) disable iff (rst)
      year_end_s ##0 (year_count == BCD_99) |=> year_count == BCD_00)
    else $error("year did not roll to 00");
  sec_write_a: assert property (@(posedge clk) disable iff (rst)
      reg_wr && reg_addr == OFS_SEC |=> seconds_count == ($past(reg_wdata) & MASK_SEC))
    else $error("seconds write lost");
  wday_upper_a: assert property (@(posedge clk) disable iff (rst)
      reg_rd && reg_addr == OFS_WDAY |=> reg_rdata[7:3] == 5'h00)
    else $error("weekday upper bits not zero");
  halt_read_a: assert property (@(posedge clk) disable iff (rst)
      reg_rd && osc_halt_detected |=> reg_rdata == UNDEF_DIGITS)
    else $error("halt read not masked");
  first_irq_a: assert property (@(posedge clk) disable iff (rst)
      first_hit_s |=> !irq_out_first_n && first_alarm_match_flag)
    else $error("first alarm match not signalled");
  second_irq_a: assert property (@(posedge clk) disable iff (rst)
      second_hit_s |=> !irq_out_second_n && second_alarm_match_flag)
    else $error("second alarm match not signalled");
endmodule : bcdrtc_core
